/* hw/pcs_pkg.sv */
/*
 package for the program counter sequencer: widths, vectors, op codes.
 assumes the core decodes instructions into one op per executed step.
*/
package pcs_pkg;
   localparam int ADDR_W = 10;
   localparam int WORD_W = 16;
   localparam int MEM_DEPTH = 1024;
   localparam int STACK_DEPTH = 5;
   localparam int STATUS_W = 5;
   localparam int BANK_W = 4;
   localparam logic [9:0] RESET_ADDR = 10'h000;
   localparam logic [9:0] VEC_LAST = 10'h003;
   localparam logic [9:0] ADDR_STEP = 10'h001;
   localparam logic [4:0] STATUS_CLR = 5'h00;
   localparam logic [3:0] BANK_CLR = 4'h0;

   typedef enum logic [2:0]
   {
      PCS_OP_NONE,
      PCS_OP_JUMP,
      PCS_OP_CALL,
      PCS_OP_JUMP_IND,
      PCS_OP_CALL_IND,
      PCS_OP_TABLE,
      PCS_OP_EXIT,
      PCS_OP_EXIT_INT
   } pcs_op_t;

   typedef struct packed
   {
      logic step;
      pcs_op_t op;
      logic [9:0] target;
   } pcs_instr_t;

   typedef struct packed
   {
      logic take;
      logic [9:0] vector;
   } pcs_irq_t;
endpackage : pcs_pkg

/* hw/pcs_top.sv */
/*
 program counter sequencer with program store, return stack and status save.
 assumes one executed instruction per asserted step, decoded by the core,
 and synchronous inputs on the single instruction clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - program store is 1024 words of 16 bits read only at the pointer.
// - the instruction pointer is a 10-bit counter selecting the next word.
// - words 000h to 003h hold the reset start and interrupt vectors.
// - with no load, the pointer steps by one per executed instruction.
// - reset clears all pointer bits so fetch starts at word zero.
// - direct jump and call load the pointer from the target field.
// - direct targets and table fetches reach the whole program space.
// - indirect jump, call and table fetch load the indirect pointer.
// - the two exit ops load the pointer from the top stack entry.
// - an accepted interrupt loads that source's vector.
// - five return entries plus one status save entry exist.
// - calls and table fetches push the return location first.
// - interrupts push return and status, then clear bank and status.
module pcs_top #(
   parameter int DEPTH = pcs_pkg::MEM_DEPTH,
   parameter int SDEPTH = pcs_pkg::STACK_DEPTH
)(
   input wire logic SYS_CLK_IN,
   input wire logic RESET_N_IN,
   input wire pcs_pkg::pcs_instr_t INSTR_IN,
   input wire pcs_pkg::pcs_irq_t IRQ_IN,
   input wire logic [9:0] IND_PTR_IN,
   input wire logic [4:0] STATUS_IN,
   input wire logic [9:0] LOAD_ADDR_IN,
   input wire logic [15:0] LOAD_DATA_IN,
   input wire logic LOAD_WE_IN,
   output logic [9:0] INSTR_POINTER_OUT,
   output logic [15:0] INSTR_WORD_OUT,
   output logic [4:0] STATUS_RESTORE_OUT,
   output logic STATUS_RESTORE_OUT_VLD,
   output logic STATUS_BANK_CLR_OUT,
   output logic [2:0] STACK_PTR_OUT
);
   logic [15:0] prog_mem [DEPTH];
   logic [9:0] ret_stack_ff [SDEPTH];
   logic [9:0] nxt_ret_stack [SDEPTH];
   logic [4:0] status_save_ff, nxt_status_save;
   logic [9:0] ptr_ff, nxt_ptr;
   logic [2:0] sp_ff, nxt_sp;
   logic [15:0] word_ff;
   logic rst_vld_ff, nxt_rst_vld;
   logic clr_ff, nxt_clr;
   logic [9:0] ret_addr;
   logic [2:0] top;

   // program store: external loader port stands in for the mask
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (LOAD_WE_IN)
      begin
         prog_mem[LOAD_ADDR_IN] <= LOAD_DATA_IN;
      end
      word_ff <= prog_mem[ptr_ff];
   end

   always_comb
   begin
      ret_addr = ptr_ff + pcs_pkg::ADDR_STEP;
      top = (sp_ff == 3'h0) ? 3'h0 : sp_ff - 3'h1;
      nxt_ptr = ptr_ff;
      nxt_sp = sp_ff;
      nxt_ret_stack = ret_stack_ff;
      nxt_status_save = status_save_ff;
      nxt_rst_vld = 1'b0;
      nxt_clr = 1'b0;
      if (IRQ_IN.take)
      begin
         // vector range checked below; full stack overwrites top entry
         nxt_ptr = IRQ_IN.vector;
         nxt_ret_stack[(sp_ff < 3'(SDEPTH)) ? sp_ff : top] = ptr_ff;
         nxt_sp = (sp_ff < 3'(SDEPTH)) ? sp_ff + 3'h1 : sp_ff;
         nxt_status_save = STATUS_IN;
         nxt_clr = 1'b1;
      end
      else if (INSTR_IN.step)
      begin
         nxt_ptr = ret_addr;
         unique case (INSTR_IN.op)
            pcs_pkg::PCS_OP_NONE:
            begin
               nxt_ptr = ret_addr;
            end
            pcs_pkg::PCS_OP_JUMP:
            begin
               nxt_ptr = INSTR_IN.target;
            end
            pcs_pkg::PCS_OP_CALL, pcs_pkg::PCS_OP_CALL_IND,
            pcs_pkg::PCS_OP_TABLE:
            begin
               // push before reload
               nxt_ret_stack[(sp_ff < 3'(SDEPTH)) ? sp_ff : top] = ret_addr;
               nxt_sp = (sp_ff < 3'(SDEPTH)) ? sp_ff + 3'h1 : sp_ff;
               nxt_ptr = (INSTR_IN.op == pcs_pkg::PCS_OP_CALL) ?
                  INSTR_IN.target : IND_PTR_IN;
            end
            pcs_pkg::PCS_OP_JUMP_IND:
            begin
               nxt_ptr = IND_PTR_IN;
            end
            pcs_pkg::PCS_OP_EXIT, pcs_pkg::PCS_OP_EXIT_INT:
            begin
               nxt_ptr = ret_stack_ff[top];
               nxt_sp = top;
               nxt_rst_vld = (INSTR_IN.op == pcs_pkg::PCS_OP_EXIT_INT);
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         ptr_ff <= pcs_pkg::RESET_ADDR;
         sp_ff <= 3'h0;
         status_save_ff <= pcs_pkg::STATUS_CLR;
         rst_vld_ff <= 1'b0;
         clr_ff <= 1'b0;
         for (int i = 0; i < SDEPTH; i++)
         begin
            ret_stack_ff[i] <= pcs_pkg::RESET_ADDR;
         end
      end
      else
      begin
         ptr_ff <= nxt_ptr;
         sp_ff <= nxt_sp;
         status_save_ff <= nxt_status_save;
         rst_vld_ff <= nxt_rst_vld;
         clr_ff <= nxt_clr;
         ret_stack_ff <= nxt_ret_stack;
      end
   end

   assign INSTR_POINTER_OUT = ptr_ff;
   assign INSTR_WORD_OUT = word_ff;
   assign STATUS_RESTORE_OUT = status_save_ff;
   assign STATUS_RESTORE_OUT_VLD = rst_vld_ff;
   assign STATUS_BANK_CLR_OUT = clr_ff;
   assign STACK_PTR_OUT = sp_ff;

   vector_range_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      IRQ_IN.take |=> ptr_ff <= pcs_pkg::VEC_LAST)
      else $error("vector outside low words");
   reset_start_a: assert property (@(posedge SYS_CLK_IN)
      !RESET_N_IN |-> ptr_ff == pcs_pkg::RESET_ADDR)
      else $error("pointer not cleared in reset");
   step_incr_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      INSTR_IN.step && !IRQ_IN.take &&
      INSTR_IN.op == pcs_pkg::PCS_OP_NONE |=>
      ptr_ff == $past(ptr_ff) + pcs_pkg::ADDR_STEP)
      else $error("pointer did not step");
   hold_idle_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      !INSTR_IN.step && !IRQ_IN.take |=> $stable(ptr_ff))
      else $error("pointer moved with no step");
   jump_load_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      INSTR_IN.step && !IRQ_IN.take &&
      INSTR_IN.op == pcs_pkg::PCS_OP_JUMP |=>
      ptr_ff == $past(INSTR_IN.target))
      else $error("direct jump target not loaded");
   ind_load_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      INSTR_IN.step && !IRQ_IN.take &&
      (INSTR_IN.op == pcs_pkg::PCS_OP_JUMP_IND ||
      INSTR_IN.op == pcs_pkg::PCS_OP_CALL_IND ||
      INSTR_IN.op == pcs_pkg::PCS_OP_TABLE) |=>
      ptr_ff == $past(IND_PTR_IN))
      else $error("indirect pointer not loaded");
   call_return_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      INSTR_IN.step && !IRQ_IN.take && sp_ff < 3'h5 &&
      INSTR_IN.op == pcs_pkg::PCS_OP_CALL ##1
      INSTR_IN.step && !IRQ_IN.take && INSTR_IN.op == pcs_pkg::PCS_OP_EXIT
      |=> ptr_ff == $past(ptr_ff, 2) + pcs_pkg::ADDR_STEP)
      else $error("call return location lost");
   irq_priority_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      IRQ_IN.take |=> ptr_ff == $past(IRQ_IN.vector) &&
      STATUS_BANK_CLR_OUT && status_save_ff == $past(STATUS_IN))
      else $error("interrupt load or save wrong");
   stack_bound_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN) sp_ff <= 3'(SDEPTH))
      else $error("stack pointer beyond five");
   exit_restore_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      INSTR_IN.step && !IRQ_IN.take && sp_ff != 3'h0 &&
      INSTR_IN.op == pcs_pkg::PCS_OP_EXIT |=>
      sp_ff == $past(sp_ff) - 3'h1)
      else $error("exit did not pop");
   call_push_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      INSTR_IN.step && !IRQ_IN.take && sp_ff < 3'(SDEPTH) &&
      (INSTR_IN.op == pcs_pkg::PCS_OP_CALL ||
      INSTR_IN.op == pcs_pkg::PCS_OP_CALL_IND ||
      INSTR_IN.op == pcs_pkg::PCS_OP_TABLE) |=> sp_ff == $past(sp_ff) + 3'h1
      && ret_stack_ff[top] == $past(ptr_ff) + pcs_pkg::ADDR_STEP)
      else $error("return location not pushed");
   irq_push_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      IRQ_IN.take && sp_ff < 3'(SDEPTH) |=>
      sp_ff == $past(sp_ff) + 3'h1 && ret_stack_ff[top] == $past(ptr_ff))
      else $error("interrupt return location not pushed");
   restore_pulse_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      INSTR_IN.step && !IRQ_IN.take &&
      INSTR_IN.op == pcs_pkg::PCS_OP_EXIT_INT |=> STATUS_RESTORE_OUT_VLD)
      else $error("status restore pulse missing");
   clear_pulse_a: assert property (@(posedge SYS_CLK_IN)
      disable iff (!RESET_N_IN)
      !IRQ_IN.take |=> !STATUS_BANK_CLR_OUT)
      else $error("bank clear pulse without interrupt");
endmodule : pcs_top
`default_nettype wire

/* testbench/pcs_mem_model.sv */
/*
 program store loader model: writes a known word to every address once.
 assumes the store write port samples on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_mem_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   output logic [9:0] addr_out,
   output logic [15:0] data_out,
   output logic we_out,
   output logic done_out
);
   // idle data inverted so a stale word never looks valid
   assign data_out = we_out ? {6'h2A, addr_out} : ~{6'h2A, addr_out};
   always @(negedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         addr_out <= 10'h000;
         we_out <= 1'b0;
         done_out <= 1'b0;
      end
      else if (we_out && addr_out == 10'h3FF)
      begin
         we_out <= 1'b0;
         done_out <= 1'b1;
      end
      else if (!done_out)
      begin
         addr_out <= addr_out + {9'h000, we_out};
         we_out <= 1'b1;
      end
   end
endmodule : pcs_mem_model
`default_nettype wire

/* testbench/program_counter_sequencer_bench.sv */
/*
 bench for the sequencer: driver notes pointers, a watcher compares them.
 assumes the loader model fills the whole store before any step.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module program_counter_sequencer_bench;
   logic clk = 1'b0, rst_n = 1'b1, mrst_n = 1'b0, we, done, bclr, vld;
   pcs_pkg::pcs_instr_t ins = '0;
   pcs_pkg::pcs_irq_t irq = '0;
   logic [9:0] ind = 10'h000, la, ptr, p, r = 10'h05E;
   logic [4:0] st = 5'h00, rst_st;
   logic [15:0] ld, word;
   logic [2:0] sp;
   logic [9:0] q[$], stk[$];
   int n_errors = 0, samples_checked = 0;
   always #4 clk = ~clk;
   pcs_mem_model pcs_mem_model_inst (.clk_in(clk), .rst_n_in(mrst_n),
      .addr_out(la), .data_out(ld), .we_out(we), .done_out(done));
   pcs_top pcs_top_inst (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
      .INSTR_IN(ins), .IRQ_IN(irq), .IND_PTR_IN(ind), .STATUS_IN(st),
      .LOAD_ADDR_IN(la), .LOAD_DATA_IN(ld), .LOAD_WE_IN(we),
      .INSTR_POINTER_OUT(ptr), .INSTR_WORD_OUT(word),
      .STATUS_RESTORE_OUT(rst_st), .STATUS_RESTORE_OUT_VLD(vld),
      .STATUS_BANK_CLR_OUT(bclr), .STACK_PTR_OUT(sp));
   function automatic logic [9:0] nx(input logic [9:0] s);
      return {s[8:0], s[9] ^ s[6]};
   endfunction : nx
   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // expected pointer worked out from a bench copy of the return stack
   task automatic go(input pcs_pkg::pcs_op_t o, input logic [9:0] t,
      input logic tk);
      logic [9:0] e;
      r = nx(r);
      ind = r;
      e = t;
      if (tk)
         stk.push_back(p);
      else if (o == pcs_pkg::PCS_OP_NONE)
         e = p + 10'h001;
      else if (o == pcs_pkg::PCS_OP_JUMP_IND || o == pcs_pkg::PCS_OP_CALL_IND
         || o == pcs_pkg::PCS_OP_TABLE)
         e = ind;
      else if (o == pcs_pkg::PCS_OP_EXIT || o == pcs_pkg::PCS_OP_EXIT_INT)
         e = stk.pop_back();
      if (!tk && (o == pcs_pkg::PCS_OP_CALL || o == pcs_pkg::PCS_OP_CALL_IND
         || o == pcs_pkg::PCS_OP_TABLE))
         stk.push_back(p + 10'h001);
      ins = '{1'b1, o, t};
      irq = '{tk, t};
      q.push_back(e);
      p = e;
      @(negedge clk);
   endtask : go
   // request from go stands until the next go or this idle cycle
   task automatic rest;
      ins = '0;
      irq = '0;
      @(negedge clk);
   endtask : rest
   always @(posedge clk)
   begin : watch
      logic rq;
      logic [9:0] ex;
      rq = ins.step | irq.take;
      #1;
      if (rq && q.size() > 0)
      begin
         ex = q.pop_front();
         `CHK("ptr", ex, ptr)
      end
   end
   initial
   begin
      #40000;
      n_errors++;
      close_out();
   end
   initial
   begin
      // a real falling edge so the async reset acts before the first clock
      #1 rst_n = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      mrst_n = 1'b1;
      wait (done);
      @(negedge clk);
      p = 10'h000;
      `CHK("ptr", 10'h000, ptr)
      repeat (3) go(pcs_pkg::PCS_OP_NONE, 10'h000, 1'b0);
      go(pcs_pkg::PCS_OP_JUMP, r, 1'b0);
      go(pcs_pkg::PCS_OP_JUMP, 10'h3FF, 1'b0);
      go(pcs_pkg::PCS_OP_NONE, 10'h000, 1'b0);
      rest();
      `CHK("word", {6'h2A, p}, word)
      go(pcs_pkg::PCS_OP_CALL, r, 1'b0);
      for (int k = 3; k < 6; k++)
         go(pcs_pkg::pcs_op_t'(k), 10'h000, 1'b0);
      `CHK("sp", 3'h3, sp)
      for (int v = 0; v < 4; v++)
      begin
         st = r[4:0];
         go(v[0] ? pcs_pkg::PCS_OP_JUMP : pcs_pkg::PCS_OP_NONE, v[9:0], 1'b1);
         `CHK("bclr", 1'b1, bclr)
         `CHK("sp", 3'h4, sp)
         go(pcs_pkg::PCS_OP_EXIT_INT, 10'h000, 1'b0);
         `CHK("vld", 1'b1, vld)
         `CHK("bclr", 1'b0, bclr)
         `CHK("status", st, rst_st)
      end
      go(pcs_pkg::PCS_OP_CALL, r, 1'b0);
      go(pcs_pkg::PCS_OP_EXIT, 10'h000, 1'b0);
      repeat (3) go(pcs_pkg::PCS_OP_EXIT, 10'h000, 1'b0);
      // reset must win over a jump and an interrupt in the same cycle
      ins = '{1'b1, pcs_pkg::PCS_OP_JUMP, 10'h3FF};
      irq = '{1'b1, 10'h002};
      rst_n = 1'b0;
      @(negedge clk);
      `CHK("ptr", 10'h000, ptr)
      `CHK("bclr", 1'b0, bclr)
      close_out();
   end
endmodule : program_counter_sequencer_bench
`default_nettype wire
